// ===== hdl/ecp_port_params.svh
// ecp engine constants
`ifndef ECP_PORT_PARAMS_SVH
`define ECP_PORT_PARAMS_SVH

// host i/o offsets
`define OFS_DATA_FIFO   11'h400
`define OFS_CMD_FIFO    11'h000

// mode field codes
`define MODE_SPP        3'h0
`define MODE_PS2        3'h1
`define MODE_FIFO       3'h2
`define MODE_ECP        3'h3
`define MODE_TEST       3'h6

// fifo entry layout: command flag above the byte
`define ENTRY_CMD_BIT   8
`define CMD_KIND_BIT    7
`define FIFO_DEPTH_VAL  16
`define THR_FIELD_MAX   4'hF
`define THR_CLAMP       5'h0F

// reset values
`define RST_MASK        1'b1
`define RST_BYTE        8'h00

// timing counts
`define CLK_PERIOD_NS   40
`define DACK_GAP_NS     350
`define DACK_GAP_CYC    ((`DACK_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_PULSE_CYC   4
`define DMA_BURST_MAX   32

`endif

// ===== hdl/ecp_port_pkg.sv
// types shared by the ecp transfer engine
package ecp_port_pkg;

  typedef logic [2:0] mode_t;

  typedef enum logic [1:0] {
    F_IDLE,
    F_STROBE,
    F_RELEASE
  } fwd_state_t;

  typedef enum logic [1:0] {
    R_WAIT,
    R_FILL,
    R_HOLD
  } rev_state_t;

endpackage : ecp_port_pkg

// ===== hdl/byte_fifo.sv
// flip-flop fifo with occupancy count and flush
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  // write side
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  output logic                            full,
  // read side
  input  wire logic                       pop,
  output logic [WIDTH-1:0]                pop_data,
  output logic                            empty,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             do_push;
  logic             do_pop;

  assign full     = (cnt_q == CW'(DEPTH));
  assign empty    = (cnt_q == '0);
  assign count    = cnt_q;
  assign pop_data = mem_q[rd_q];
  // push when full and pop when empty are dropped
  assign do_push  = push && !full;
  assign do_pop   = pop && !empty;

  // storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : byte_fifo

// ===== hdl/irq_pulser.sv
// shared interrupt line: short low pulse, restarted by each event
`timescale 1ns/1ps
`include "ecp_port_params.svh"
module irq_pulser #(
  parameter int PULSE = `IRQ_PULSE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // event in
  input  wire logic fire,
  // line out
  output logic      line_o,
  output logic      line_oe_n
);
  logic [7:0] left_q;

  assign line_o = 1'b0;

  // an event during a pulse restarts it, so nothing is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q    <= 8'h00;
      line_oe_n <= 1'b1;
    end else if (fire) begin
      left_q    <= 8'(PULSE - 1);
      line_oe_n <= 1'b0;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end else begin
      line_oe_n <= 1'b1;
    end
  end
endmodule : irq_pulser

// ===== hdl/ecp_port.sv
// ecp port transfer engine
`timescale 1ns/1ps
`include "ecp_port_params.svh"

// Function
// - forward hostack high for data, low command
// - command bit7: 0 run count, 1 channel
// - reverse run count replicates next byte count+1
// - control lines open collector only mode 000
// - mask set blocks dma requests and service and tc interrupts; fault and ack interrupts ignore it
// - mask clear with condition valid interrupts immediately
// - interrupt is brief low pulse then released
// - terminal count interrupts and sets mask
// - forward pio interrupts on enough free bytes
// - reverse pio interrupts on enough stored bytes
// - fault falling edge or enable arming interrupts
// - ack rising edge interrupts when enabled
// - fifo disabled after reset, fifo modes only
// - threshold is field plus one, 16 as 15
// - dma access on acknowledge ignoring address; tc
// - request dropped after 32 cycles until gap
// - reverse request while data, drop empty or tc
// - after tc, re-request needs byte and mask cleared
// - data fifo 400h, command fifo 000h write-only
// - trigger levels are sixteen minus threshold
// - mode 011 transfers fifo with ecp handshake
module ecp_port
  import ecp_port_pkg::*;
#(
  parameter int DEPTH     = `FIFO_DEPTH_VAL,
  parameter int DACK_GAP  = `DACK_GAP_CYC,
  parameter int IRQ_PULSE = `IRQ_PULSE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host i/o access
  input  wire logic [10:0] host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  output logic [7:0]       host_rdata,
  // host dma
  output logic             port_dma_request,
  input  wire logic        port_dma_acknowledge_low,
  input  wire logic        dma_terminal_count,
  // configuration and control
  input  wire logic [2:0]  mode,
  input  wire logic        direction,
  input  wire logic        dma_request_enable,
  input  wire logic        mask_set,
  input  wire logic        mask_clear,
  output logic             service_interrupt_mask,
  input  wire logic        fault_interrupt_enable_low,
  input  wire logic        acknowledge_interrupt_enable,
  input  wire logic [3:0]  fifo_threshold_field,
  // software line levels
  input  wire logic [7:0]  ctl_data,
  input  wire logic        ctl_strobe_low,
  input  wire logic        ctl_autofd_low,
  input  wire logic        ctl_init_low,
  input  wire logic        ctl_select_in_low,
  // status
  output logic             fifo_empty,
  output logic             fifo_full,
  output logic [4:0]       fifo_level,
  // cable: data pins
  input  wire logic [7:0]  pd_i,
  output logic [7:0]       pd_o,
  output logic             pd_oe_n,
  // cable: control outputs
  output logic [3:0]       ctl_line_o,
  output logic [3:0]       ctl_line_oe_n,
  // cable: peripheral inputs
  input  wire logic        busy_periph_ack,
  input  wire logic        ack_low,
  input  wire logic        fault_low,
  // interrupt line
  output logic             port_interrupt_line_o,
  output logic             port_interrupt_line_oe_n
);
  localparam int CW = $clog2(DEPTH+1);

  // fifo connections
  logic          push;
  logic [8:0]    push_data;
  logic          pop;
  logic [8:0]    head;
  logic          full;
  logic          empty;
  logic [CW-1:0] count;
  logic          flush;

  // mode decode
  logic fifo_on;
  logic engine_on;
  logic fwd_run;
  logic rev_run;

  // host and dma access
  logic dack;
  logic dma_cycle;
  logic pio_wr_data;
  logic pio_wr_cmd;
  logic pio_rd;

  // engine state
  fwd_state_t fwd_q;
  rev_state_t rev_q;
  logic [7:0] pd_q;
  logic       hostack_q;
  logic       strobe_low_q;
  logic       rev_busy_q;
  logic [7:0] rev_byte_q;
  logic [6:0] rle_cnt_q;
  logic       rle_pend_q;
  logic [7:0] rep_q;
  logic       rev_push;
  logic       fwd_pop;

  // flow control and interrupt state
  logic       mask_q;
  logic [5:0] burst_q;
  logic       hold_q;
  logic [7:0] gap_q;
  logic       tc_hit;
  logic [4:0] thr_eff;
  logic [4:0] fill_trigger_level;
  logic [4:0] free_space_trigger_level;
  logic [4:0] free_bytes;
  logic       svc_cond;
  logic       svc_cond_q;
  logic       fault_q;
  logic       ack_q;
  logic       err_en_low_q;
  logic       irq_fire;
  logic [7:0] rdata_q;

  // fifo lives in fifo, ecp and test modes
  assign fifo_on   = (mode == `MODE_FIFO) || (mode == `MODE_ECP) || (mode == `MODE_TEST);
  assign flush     = !fifo_on;
  assign engine_on = (mode == `MODE_ECP) || ((mode == `MODE_FIFO) && !direction);
  assign fwd_run   = engine_on && !direction;
  assign rev_run   = engine_on && direction && (mode == `MODE_ECP);

  // dma ignores the address; pio decodes it
  assign dack        = !port_dma_acknowledge_low;
  assign dma_cycle   = dack && (host_wr || host_rd) && fifo_on;
  assign pio_wr_data = !dack && host_wr && (host_addr == `OFS_DATA_FIFO) && fifo_on;
  assign pio_wr_cmd  = !dack && host_wr && (host_addr == `OFS_CMD_FIFO) && (mode == `MODE_ECP) && !direction;
  assign pio_rd      = !dack && host_rd && (host_addr == `OFS_DATA_FIFO) && fifo_on;
  assign tc_hit      = dma_cycle && dma_terminal_count;

  // fifo push: host side in forward and test, link side in reverse
  always_comb begin
    push      = 1'b0;
    push_data = {1'b0, host_wdata};
    if (rev_run) begin
      push      = rev_push;
      push_data = {1'b0, rev_byte_q};
    end else if (pio_wr_cmd) begin
      push      = 1'b1;
      push_data = {1'b1, host_wdata};
    end else if (pio_wr_data || (dma_cycle && host_wr)) begin
      push = 1'b1;
    end
  end

  // fifo pop: link side in forward, host side in reverse and test
  assign pop = fwd_run ? fwd_pop : (pio_rd || (dma_cycle && host_rd));

  byte_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush),
    .push      (push),
    .push_data (push_data),
    .full      (full),
    .pop       (pop),
    .pop_data  (head),
    .empty     (empty),
    .count     (count)
  );

  assign fifo_empty = empty;
  assign fifo_full  = full;
  assign fifo_level = 5'(count);

  // read data; an empty fifo repeats the last byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `RST_BYTE;
    end else if (pop && !fwd_run && !empty) begin
      rdata_q <= head[7:0];
    end
  end
  assign host_rdata = rdata_q;

  // forward engine: strobe, wait busy high, release, wait busy low
  assign fwd_pop = fwd_run && (fwd_q == F_IDLE) && !empty;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_q        <= F_IDLE;
      pd_q         <= `RST_BYTE;
      hostack_q    <= 1'b1;
      strobe_low_q <= 1'b1;
    end else if (!fwd_run) begin
      fwd_q        <= F_IDLE;
      strobe_low_q <= 1'b1;
      hostack_q    <= 1'b1;
    end else begin
      case (fwd_q)
        F_IDLE: begin
          if (!empty) begin
            pd_q         <= head[7:0];
            hostack_q    <= !head[`ENTRY_CMD_BIT] || (mode != `MODE_ECP);
            strobe_low_q <= 1'b0;
            fwd_q        <= F_STROBE;
          end
        end
        F_STROBE: begin
          if (busy_periph_ack) begin
            strobe_low_q <= 1'b1;
            fwd_q        <= F_RELEASE;
          end
        end
        F_RELEASE: begin
          if (!busy_periph_ack) begin
            fwd_q <= F_IDLE;
          end
        end
        default: begin
          fwd_q <= F_IDLE;
        end
      endcase
    end
  end

  // reverse engine: catch on ack low, expand runs
  assign rev_push = (rev_q == R_FILL) && !full;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rev_q      <= R_WAIT;
      rev_busy_q <= 1'b0;
      rev_byte_q <= `RST_BYTE;
      rle_cnt_q  <= 7'h00;
      rle_pend_q <= 1'b0;
      rep_q      <= 8'h00;
    end else if (!rev_run) begin
      rev_q      <= R_WAIT;
      rev_busy_q <= 1'b0; // autofd deasserted on leaving the mode
      rle_pend_q <= 1'b0;
    end else begin
      case (rev_q)
        R_WAIT: begin
          // take a byte only when it fits; the peripheral waits
          if (!ack_low && !full) begin
            rev_busy_q <= 1'b1;
            rev_byte_q <= pd_i;
            if (!busy_periph_ack) begin
              if (!pd_i[`CMD_KIND_BIT]) begin
                rle_cnt_q  <= pd_i[6:0];
                rle_pend_q <= 1'b1;
              end
              rev_q <= R_HOLD; // channel addresses are dropped
            end else begin
              rep_q      <= rle_pend_q ? {1'b0, rle_cnt_q} : 8'h00;
              rle_pend_q <= 1'b0;
              rev_q      <= R_FILL;
            end
          end
        end
        R_FILL: begin
          if (!full) begin
            if (rep_q == 8'h00) begin
              rev_q <= R_HOLD;
            end else begin
              rep_q <= rep_q - 8'h01;
            end
          end
        end
        R_HOLD: begin
          if (ack_low) begin
            rev_busy_q <= 1'b0;
            rev_q      <= R_WAIT;
          end
        end
        default: begin
          rev_q <= R_WAIT;
        end
      endcase
    end
  end

  // cable drivers: open collector only in mode 000
  always_comb begin
    ctl_line_o[0] = fwd_run ? strobe_low_q : ctl_strobe_low;
    ctl_line_o[1] = rev_run ? rev_busy_q : (fwd_run ? hostack_q : ctl_autofd_low);
    ctl_line_o[2] = ctl_init_low;
    ctl_line_o[3] = ctl_select_in_low;
    if (mode == `MODE_SPP) begin
      ctl_line_oe_n = ctl_line_o;
    end else begin
      ctl_line_oe_n = 4'h0;
    end
  end
  assign pd_o    = fwd_run ? pd_q : ctl_data;
  assign pd_oe_n = direction && (mode != `MODE_SPP);

  // service mask: set and terminal count win over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= `RST_MASK;
    end else if (mask_set || (tc_hit && !mask_q && dma_request_enable)) begin
      mask_q <= 1'b1;
    end else if (mask_clear) begin
      mask_q <= 1'b0;
    end
  end
  assign service_interrupt_mask = mask_q;

  // burst limit: hold off after 32 cycles until a long enough gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_q <= 6'h00;
      hold_q  <= 1'b0;
      gap_q   <= 8'h00;
    end else begin
      if (dack) begin
        gap_q <= 8'h00;
      end else if (gap_q != 8'hFF) begin
        gap_q <= gap_q + 8'h01;
      end
      if (dma_cycle) begin
        burst_q <= burst_q + 6'h01;
        if (burst_q == 6'(`DMA_BURST_MAX - 1)) begin
          hold_q <= 1'b1;
        end
      end else if (!dack && (gap_q >= 8'(DACK_GAP - 1))) begin
        burst_q <= 6'h00;
        hold_q  <= 1'b0;
      end
    end
  end

  // dma request; terminal count drops it, its mask keeps it down
  always_comb begin
    port_dma_request = 1'b0;
    if (dma_request_enable && !mask_q && fifo_on && !hold_q && !tc_hit) begin
      if (direction) begin
        port_dma_request = !empty && !(dma_cycle && host_rd && (count == CW'(1)));
      end else begin
        port_dma_request = !full;
      end
    end
  end

  // threshold: field plus one, with 16 clamped to 15
  assign thr_eff = (fifo_threshold_field == `THR_FIELD_MAX) ? `THR_CLAMP
                                                             : {1'b0, fifo_threshold_field} + 5'h01;
  assign fill_trigger_level       = 5'(DEPTH) - thr_eff;
  assign free_space_trigger_level = 5'(DEPTH) - thr_eff;
  assign free_bytes               = 5'(DEPTH) - 5'(count);

  // pio service condition; its rise also covers unmasking
  always_comb begin
    svc_cond = 1'b0;
    if (!mask_q && !dma_request_enable && fifo_on) begin
      if (direction) begin
        svc_cond = (5'(count) >= fill_trigger_level);
      end else begin
        svc_cond = (free_bytes >= free_space_trigger_level);
      end
    end
  end

  // edge history of the service condition, the cable inputs and the fault enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      svc_cond_q   <= 1'b0;
      fault_q      <= 1'b1;
      ack_q        <= 1'b1;
      err_en_low_q <= 1'b1;
    end else begin
      svc_cond_q   <= svc_cond;
      fault_q      <= fault_low;
      ack_q        <= ack_low;
      err_en_low_q <= fault_interrupt_enable_low;
    end
  end

  // events in one cycle or during a pulse share one pulse, keeping the shared line edge friendly
  assign irq_fire = (svc_cond && !svc_cond_q)
                 || (tc_hit && !mask_q && dma_request_enable)
                 || (!fault_interrupt_enable_low && fault_q && !fault_low)
                 || (!fault_interrupt_enable_low && err_en_low_q && !fault_low)
                 || (acknowledge_interrupt_enable && !ack_q && ack_low);

  irq_pulser #(
    .PULSE (IRQ_PULSE)
  ) u_irq (
    .clk       (clk),
    .rst       (rst),
    .fire      (irq_fire),
    .line_o    (port_interrupt_line_o),
    .line_oe_n (port_interrupt_line_oe_n)
  );

endmodule : ecp_port

// ===== test/ecp_port_assertions.sv
// port-level checker for the ecp transfer engine
`timescale 1ns/1ps
module ecp_port_assertions
  import ecp_port_pkg::*;
#(
  parameter int DACK_GAP = 9
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // host and dma
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic       port_dma_request,
  input wire logic       port_dma_acknowledge_low,
  input wire logic       dma_terminal_count,
  // control
  input wire logic [2:0] mode,
  input wire logic       direction,
  input wire logic       dma_request_enable,
  input wire logic       service_interrupt_mask,
  input wire logic       fault_interrupt_enable_low,
  input wire logic       acknowledge_interrupt_enable,
  // status and lines
  input wire logic       fifo_empty,
  input wire logic [3:0] ctl_line_o,
  input wire logic [3:0] ctl_line_oe_n,
  input wire logic       ack_low,
  input wire logic       fault_low,
  input wire logic       port_interrupt_line_o,
  input wire logic       port_interrupt_line_oe_n
);
  logic       dma_cyc;
  logic [5:0] burst_q;
  logic [4:0] gap_q;
  assign dma_cyc = !port_dma_acknowledge_low && (host_wr || host_rd);
  // dma cycles since acknowledge last stayed high long enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_q <= 6'h00;
      gap_q   <= 5'h00;
    end else if (port_dma_acknowledge_low) begin
      gap_q <= gap_q + 5'h01;
      if (gap_q >= 5'(DACK_GAP - 1)) burst_q <= 6'h00;
    end else begin
      gap_q <= 5'h00;
      if (dma_cyc) burst_q <= burst_q + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_MASK_NO_REQ: assert property (service_interrupt_mask |-> !port_dma_request)
    else $error("request while masked");
  AST_IRQ_PULSE: assert property ($fell(port_interrupt_line_oe_n) |->
    (!port_interrupt_line_oe_n && !port_interrupt_line_o)[*4] ##[1:40] port_interrupt_line_oe_n)
    else $error("bad irq pulse");
  AST_TC_MASK_IRQ: assert property (dma_cyc && dma_terminal_count && !service_interrupt_mask
    && dma_request_enable && mode[1] && !(&mode) |=> service_interrupt_mask && !port_interrupt_line_oe_n)
    else $error("tc missed");
  AST_TC_DROP_REQ: assert property (dma_cyc && dma_terminal_count |-> !port_dma_request)
    else $error("request kept on tc");
  AST_BURST_LIMIT: assert property (burst_q >= 6'h20 |-> !port_dma_request)
    else $error("burst too long");
  AST_RESET_STATE: assert property ($fell(rst) |-> service_interrupt_mask && fifo_empty && !port_dma_request)
    else $error("bad reset state");
  AST_PUSH_PULL: assert property (mode != 3'h0 |-> ctl_line_oe_n == 4'h0)
    else $error("not push-pull");
  AST_OPEN_COLL: assert property (mode == 3'h0 |-> ctl_line_oe_n == ctl_line_o)
    else $error("not open collector");
  AST_UNMASK_IRQ: assert property ($fell(service_interrupt_mask) && !dma_request_enable && !direction
    && mode == 3'h3 && fifo_empty |-> ##[1:2] !port_interrupt_line_oe_n)
    else $error("no unmask irq");
  AST_ACK_IRQ: assert property (acknowledge_interrupt_enable && $rose(ack_low)
    |-> ##[1:3] !port_interrupt_line_oe_n)
    else $error("no ack irq");
  AST_FAULT_IRQ: assert property ((!fault_interrupt_enable_low && $fell(fault_low)) ||
    ($fell(fault_interrupt_enable_low) && !fault_low) |-> ##[1:3] !port_interrupt_line_oe_n)
    else $error("no fault irq");
  // main scenarios reached
  cover property (dma_cyc && dma_terminal_count);
  cover property (burst_q == 6'h20);
  cover property ($fell(port_interrupt_line_oe_n));
endmodule : ecp_port_assertions

bind ecp_port ecp_port_assertions #(.DACK_GAP(DACK_GAP)) ecp_port_assertions_inst (.*);

// ===== test/ecp_periph_model.sv
// behavioural ecp peripheral on the cable side
`timescale 1ns/1ps
module ecp_periph_model (
  // cable from the port
  input  wire logic       clk,
  input  wire logic [7:0] pd_o,
  input  wire logic       pd_oe_n,
  input  wire logic [3:0] ctl_line_o,
  input  wire logic [3:0] ctl_line_oe_n,
  // cable to the port
  output logic [7:0]      pd_i,
  output logic            busy_periph_ack,
  output logic            ack_low,
  output logic            fault_low
);
  logic [3:0] lvl;
  logic [8:0] rx_q[$];
  int         lag = 2;
  // an undriven control line floats to its pull-up
  assign lvl = ctl_line_o | ctl_line_oe_n;
  initial {pd_i, busy_periph_ack, ack_low, fault_low} = 11'h003;
  // forward receiver: latch {hostack, byte} on strobe, busy after lag cycles
  always @(posedge clk) begin
    if (!lvl[0] && !busy_periph_ack && !pd_oe_n) begin
      rx_q.push_back({lvl[1], pd_o});
      repeat (lag) @(posedge clk);
      busy_periph_ack <= 1'b1;
      wait (lvl[0]);
      @(posedge clk);
      busy_periph_ack <= 1'b0;
    end
  end
  // reverse sender: periph ack level marks data (high) or command (low)
  task automatic send(input logic [7:0] b, input logic is_data);
    @(posedge clk);
    pd_i            <= b;
    busy_periph_ack <= is_data;
    ack_low         <= 1'b0;
    wait (lvl[1]);
    @(posedge clk);
    ack_low <= 1'b1;
    pd_i    <= ~b; // byte no longer held, so show no stale copy
    wait (!lvl[1]);
  endtask : send
  // status pins under bench control
  task automatic pins(input logic f, input logic a);
    fault_low <= f;
    ack_low   <= a;
  endtask : pins
endmodule : ecp_periph_model

// ===== test/tb_top.sv
// self-checking bench for the ecp transfer engine
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] host_addr;
  logic host_wr, host_rd, port_dma_acknowledge_low, dma_terminal_count, direction, dma_request_enable;
  logic mask_set, mask_clear, fault_interrupt_enable_low, acknowledge_interrupt_enable;
  logic ctl_strobe_low, ctl_autofd_low, ctl_init_low, ctl_select_in_low;
  logic [7:0] host_wdata, ctl_data, host_rdata, pd_i, pd_o;
  logic [3:0] fifo_threshold_field, ctl_line_o, ctl_line_oe_n, ctl_lv;
  logic [2:0] mode;
  logic port_dma_request, service_interrupt_mask, fifo_empty, fifo_full, pd_oe_n, busy_periph_ack;
  logic ack_low, fault_low, port_interrupt_line_o, port_interrupt_line_oe_n;
  logic [4:0] fifo_level;
  logic [7:0] lfsr_q = 8'h55;
  logic [8:0] exp_q[$];
  logic [8:0] fwd[4] = '{9'h005, 9'h1C3, 9'h083, 9'h17F};
  assign {ctl_select_in_low, ctl_init_low, ctl_autofd_low, ctl_strobe_low} = ctl_lv;
  int n_mismatch = 0;
  int total_checks = 0;
  int irq_cnt = 0;

  ecp_port ecp_port_inst (.*);
  ecp_periph_model periph (.*);

  always #20 clk = ~clk;
  // interrupt pulses seen
  always @(negedge port_interrupt_line_oe_n) irq_cnt++;

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[6:0], ^(lfsr_q & 8'hB8)};
    return lfsr_q;
  endfunction : rnd
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // strobes held across calls; rel drops them
  task automatic acc(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic dma);
    host_wr = wr;
    host_rd = !wr;
    host_addr = a;
    host_wdata = d;
    port_dma_acknowledge_low = !dma;
    tick();
  endtask : acc
  task automatic rel();
    {host_wr, host_rd} = 2'b00;
    port_dma_acknowledge_low = 1'b1;
  endtask : rel
  task automatic unmask();
    mask_clear = 1'b1;
    tick();
    mask_clear = 1'b0;
  endtask : unmask
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // watchdog, well past the run length
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    int n;
    int t;
    logic [7:0] b;
    logic [7:0] b2;
    {host_wr, host_rd, host_addr, host_wdata, dma_terminal_count, direction, dma_request_enable} = '0;
    {mask_set, mask_clear, acknowledge_interrupt_enable, fifo_threshold_field, ctl_data} = '0;
    {port_dma_acknowledge_low, fault_interrupt_enable_low} = 2'b11;
    ctl_lv = 4'hF;
    mode = 3'h0;
    tick(5);
    rst = 1'b0;
    check("mask", service_interrupt_mask, 1'b1);
    check("empty", fifo_empty, 1'b1);
    check("req", port_dma_request, 1'b0);
    // control line drivers in every mode
    for (int i = 0; i < 8; i++) begin
      mode = 3'(i);
      ctl_lv = 4'(rnd());
      tick();
      check("ctl_oe_n", ctl_line_oe_n, (mode == 3'h0) ? ctl_lv : 4'h0);
    end
    ctl_lv = 4'hF;
    // test mode: fill past full, drain
    mode = 3'h6;
    acc(1'b1, 11'h000, 8'hAA, 1'b0);
    rel();
    tick();
    check("cmd ignored", fifo_empty, 1'b1);
    for (int i = 0; i < 17; i++) begin
      b = rnd();
      acc(1'b1, 11'h400, b, 1'b0);
      if (exp_q.size() < 16) exp_q.push_back({1'b0, b});
    end
    rel();
    check("full", fifo_full, 1'b1);
    check("level", fifo_level, 5'h10);
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 11'h400, 8'h00, 1'b0);
      check("pio rd", host_rdata, exp_q.pop_front());
    end
    rel();
    mode = 3'h0;
    tick();
    // forward ecp, slow peripheral
    mode = 3'h3;
    fifo_threshold_field = 4'hF;
    periph.lag = 4;
    periph.rx_q.delete();
    n = irq_cnt;
    unmask();
    tick(3);
    check("unmask irq", 9'(irq_cnt), 9'(n + 1));
    foreach (fwd[i]) begin
      acc(1'b1, fwd[i][8] ? 11'h400 : 11'h000, fwd[i][7:0], 1'b0);
      exp_q.push_back(fwd[i]);
    end
    rel();
    for (t = 0; t < 400 && periph.rx_q.size() < 4; t++) tick();
    foreach (fwd[i]) check("link byte", periph.rx_q.pop_front(), exp_q.pop_front());
    mask_set = 1'b1;
    tick();
    mask_set = 1'b0;
    mode = 3'h0;
    tick();
    // dma in test mode: burst limit, then terminal count
    mode = 3'h6;
    dma_request_enable = 1'b1;
    unmask();
    check("req on", port_dma_request, 1'b1);
    for (int i = 0; i < 32; i++) begin
      if (!i[0]) b = rnd();
      acc(!i[0], 11'h7FF, b, 1'b1);
      if (i[0]) check("dma rd", host_rdata, b);
    end
    check("burst stop", port_dma_request, 1'b0);
    rel();
    tick(6);
    check("gap hold", port_dma_request, 1'b0);
    for (t = 0; t < 12 && !port_dma_request; t++) tick();
    check("req back", port_dma_request, 1'b1);
    n = irq_cnt;
    {host_wr, dma_terminal_count, port_dma_acknowledge_low} = 3'b110;
    host_wdata = rnd();
    #1 check("tc drop", port_dma_request, 1'b0);
    tick();
    rel();
    dma_terminal_count = 1'b0;
    check("tc mask", service_interrupt_mask, 1'b1);
    check("tc no req", port_dma_request, 1'b0);
    tick(2);
    check("tc irq", 9'(irq_cnt), 9'(n + 1));
    mode = 3'h0;
    tick();
    // reverse ecp with run length, read by dma
    direction = 1'b1;
    mode = 3'h3;
    unmask();
    b = rnd();
    b2 = rnd();
    periph.send(8'h03, 1'b0);
    periph.send(b, 1'b1);
    periph.send(8'h00, 1'b0);
    periph.send(b2, 1'b1);
    repeat (4) exp_q.push_back({1'b0, b});
    exp_q.push_back({1'b0, b2});
    tick(6);
    check("rev req", port_dma_request, 1'b1);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 11'h400, 8'h00, 1'b1);
      check("rle byte", host_rdata, exp_q.pop_front());
    end
    rel();
    check("rev empty", fifo_empty, 1'b1);
    check("rev req off", port_dma_request, 1'b0);
    // fault and acknowledge interrupts
    mode = 3'h0;
    direction = 1'b0;
    dma_request_enable = 1'b0;
    n = irq_cnt;
    fault_interrupt_enable_low = 1'b0;
    periph.pins(1'b0, 1'b1);
    tick(8);
    check("fault irq", 9'(irq_cnt), 9'(n + 1));
    fault_interrupt_enable_low = 1'b1;
    tick();
    fault_interrupt_enable_low = 1'b0;
    tick(8);
    check("arm irq", 9'(irq_cnt), 9'(n + 2));
    for (int i = 0; i < 2; i++) begin
      acknowledge_interrupt_enable = !i[0];
      periph.pins(1'b0, 1'b0);
      tick(2);
      periph.pins(1'b0, 1'b1);
      tick(8);
      check("ack irq", 9'(irq_cnt), 9'(n + 3));
    end
    finish_test();
  end
endmodule : tb_top
